// ---- logic/rcis_defines.svh ----
// constants for the reset cause and initial state block
`ifndef RCIS_DEFINES_SVH
`define RCIS_DEFINES_SVH

// ---------------------------------------------------------------
// start-up delay in system clocks
// ---------------------------------------------------------------
`define RCIS_SST_RC_CLKS      11'd16
`define RCIS_SST_XTAL_CLKS    11'd1024
`define RCIS_SST_INTERNAL_SLOW_RC_CLKS    11'd2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RCIS_PC_RESET         13'h0000
`define RCIS_SP_RESET         4'h0
`define RCIS_INTEN_RESET      8'h00
`define RCIS_PORT_DIR_RESET   8'hFF
`define RCIS_ANALOG_SEL_RESET 12'hFFF
`define RCIS_TIMER_EN_RESET   2'h0

// ---------------------------------------------------------------
// flag field positions in the cause word
// ---------------------------------------------------------------
`define RCIS_FLAG_TO_BIT      1
`define RCIS_FLAG_PD_BIT      0

`endif

// ---- logic/rcis_pkg.sv ----
// types for the reset cause and initial state block
package rcis_pkg;

    typedef enum logic [1:0] {
        RCIS_CLK_RC,
        RCIS_CLK_XTAL,
        RCIS_CLK_INTERNAL_SLOW_RC
    } rcis_clk_src_t;

    typedef enum logic [1:0] {
        RCIS_CAUSE_NONE,
        RCIS_CAUSE_PIN_LV,
        RCIS_CAUSE_WDT_RUN,
        RCIS_CAUSE_WDT_LOWPWR
    } rcis_cause_t;

    typedef enum logic [1:0] {
        RCIS_ST_RUN,
        RCIS_ST_HOLD,
        RCIS_ST_START
    } rcis_state_t;

    // reset cause flags as seen in the status register
    typedef struct packed {
        logic watchdog_timeout_flag;
        logic power_down_flag;
    } rcis_flags_t;

    // initial-state controls driven into the core
    typedef struct packed {
        logic [12:0] pc;
        logic [3:0]  sp;
        logic [7:0]  int_enable;
        logic        watchdog_clear;
        logic [1:0]  timer_enable;
        logic [7:0]  port_dir;
        logic [11:0] analog_input_pins;
    } rcis_init_t;

    typedef struct packed {
        rcis_state_t   state;
        rcis_cause_t   cause;
        logic          por_seen;
        logic [10:0]   count;
        logic          core_reset_n;
        rcis_flags_t   flags;
        rcis_init_t    init;
    } rcis_top_state_t;

    typedef struct packed {
        logic [1:0] pin_n;
        logic [1:0] low_voltage_reset;
        logic [1:0] wdt;
        logic [1:0] lowpwr;
    } rcis_sync_t;

endpackage : rcis_pkg

// ---- logic/rcis_sync.sv ----
// two-flop synchronisers for the asynchronous reset sources
`timescale 1ns/1ps
module rcis_sync
    import rcis_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             resetn_in,
    // raw and synchronised levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ---------------------------------------------------------------
    // one flop pair per bit
    // ---------------------------------------------------------------
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge ref_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign sync_out = sync_q;
endmodule : rcis_sync

// ---- logic/rcis_top.sv ----
// reset cause classification and post-reset initial state
//
// Contract
// RL1 - keep watchdog timeout and power-down flags; power-on clears both to 0
// RL2 - pin or low-voltage reset in run modes leaves both flags unchanged
// RL3 - watchdog reset in normal or slow mode sets timeout flag only
// RL4 - watchdog reset in idle or sleep sets both flags
// RL5 - power-on reset disables every interrupt enable
// RL6 - power-on clears watchdog counter; it then counts without software
// RL7 - power-on turns timer and event counters off
// RL8 - power-on makes all port pins inputs, analog pins to converter
// RL9 - power-on sets program counter zero and stack pointer to top
// RL10 - each state bit is loaded, kept or left per reset type
// RL11 - low-power watchdog reset clears only PC and SP, sets flags
// RL12 - wait oscillator start-up delay per clock source before running
// RL13 - priority power-on, then pin/low-voltage, then watchdog
// RL14 - hold internal reset until sources released and delay elapsed
`timescale 1ns/1ps
`include "rcis_defines.svh"
module rcis_top
    import rcis_pkg::*;
(
    // clock and power-on reset (from the supply monitor)
    input  wire logic          ref_clk_in,
    input  wire logic          resetn_in,
    // reset sources, asynchronous to the clock
    input  wire logic          external_reset_pin_n_in,
    input  wire logic          low_voltage_reset_in,
    input  wire logic          watchdog_timer_timeout_in,
    input  wire logic          low_power_mode_in,
    // configuration
    input  wire rcis_clk_src_t clk_src_in,
    // status and core controls
    output logic               core_reset_n_out,
    output rcis_flags_t        flags_out,
    output rcis_init_t         init_out,
    output logic               por_seen_out
);
    rcis_top_state_t q;
    rcis_top_state_t d;
    logic [3:0]      raw;
    logic [3:0]      synced;
    logic            pin_act;
    logic            lvr_act;
    logic            wdt_act;
    logic            lowpwr;
    logic            any_src;
    logic [10:0]     sst_clks;
    logic            sst_done;
    rcis_cause_t     new_cause;

    // ---------------------------------------------------------------
    // reset source synchronisers
    // ---------------------------------------------------------------
    // pin, supply monitor and watchdog levels are not on this clock
    assign raw = {~external_reset_pin_n_in, low_voltage_reset_in,
                  watchdog_timer_timeout_in, low_power_mode_in};

    rcis_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .async_in   (raw),
        .sync_out   (synced)
    );

    assign pin_act = synced[3];
    assign lvr_act = synced[2];
    assign wdt_act = synced[1];
    assign lowpwr  = synced[0];
    assign any_src = pin_act | lvr_act | wdt_act;

    // ---------------------------------------------------------------
    // start-up delay select
    // ---------------------------------------------------------------
    always_comb begin
        case (clk_src_in)  // see RL12
            RCIS_CLK_XTAL: sst_clks = `RCIS_SST_XTAL_CLKS;
            RCIS_CLK_INTERNAL_SLOW_RC: sst_clks = `RCIS_SST_INTERNAL_SLOW_RC_CLKS;
            default:       sst_clks = `RCIS_SST_RC_CLKS;
        endcase
    end

    // the last count is reached one edge before release
    assign sst_done = (q.count + 11'h001) >= sst_clks;  // see RL12

    // ---------------------------------------------------------------
    // cause classification
    // ---------------------------------------------------------------
    always_comb begin
        // pin/low-voltage outranks watchdog when both arrive
        if (pin_act || lvr_act) begin  // see RL13
            new_cause = RCIS_CAUSE_PIN_LV;
        end else if (wdt_act && lowpwr) begin  // see RL4
            new_cause = RCIS_CAUSE_WDT_LOWPWR;
        end else if (wdt_act) begin  // see RL3
            new_cause = RCIS_CAUSE_WDT_RUN;
        end else begin
            new_cause = RCIS_CAUSE_NONE;
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        // held through power-on, then one cycle of clear at each later release except a low-power watchdog one
        d.init.watchdog_clear = q.por_seen;  // see RL6
        case (q.state)
            RCIS_ST_RUN: begin
                // any source drops the core at once and records its cause; its state waits for release
                if (any_src) begin
                    d.cause        = new_cause;
                    d.state        = RCIS_ST_HOLD;
                    d.core_reset_n = 1'b0;
                end
            end
            RCIS_ST_HOLD: begin
                // an upgrade to pin/low-voltage while holding wins
                if (pin_act || lvr_act) begin  // see RL13
                    d.cause = RCIS_CAUSE_PIN_LV;
                end
                // counting starts only once every source has dropped
                if (!any_src) begin  // see RL14
                    d.state = RCIS_ST_START;
                    d.count = 11'h000;
                end
            end
            RCIS_ST_START: begin
                // a source returning mid-count restarts the whole delay
                if (any_src) begin
                    d.state = RCIS_ST_HOLD;
                end else if (sst_done) begin  // see RL12
                    d.state        = RCIS_ST_RUN;
                    d.core_reset_n = 1'b1;  // see RL14
                    d.por_seen     = 1'b0;
                    // apply the initial state for the taken cause
                    d.init.pc = `RCIS_PC_RESET;  // see RL9
                    d.init.sp = `RCIS_SP_RESET;  // see RL11
                    case (q.cause)
                        RCIS_CAUSE_PIN_LV: begin
                            // flags untouched, peripherals reloaded
                            d.flags                  = q.flags;  // see RL2
                            d.init.int_enable        = `RCIS_INTEN_RESET;
                            d.init.watchdog_clear    = 1'b1;
                            d.init.timer_enable      = `RCIS_TIMER_EN_RESET;
                            d.init.port_dir          = `RCIS_PORT_DIR_RESET;
                            d.init.analog_input_pins = `RCIS_ANALOG_SEL_RESET;
                        end
                        RCIS_CAUSE_WDT_RUN: begin
                            d.flags.watchdog_timeout_flag = 1'b1;  // see RL3
                            d.flags.power_down_flag       = q.flags.power_down_flag;
                            d.init.int_enable        = `RCIS_INTEN_RESET;  // see RL10
                            d.init.watchdog_clear    = 1'b1;
                            d.init.timer_enable      = `RCIS_TIMER_EN_RESET;
                            d.init.port_dir          = `RCIS_PORT_DIR_RESET;
                            d.init.analog_input_pins = `RCIS_ANALOG_SEL_RESET;
                        end
                        RCIS_CAUSE_WDT_LOWPWR: begin
                            // the core restarts at PC zero, but peripherals are kept as they were
                            d.flags.watchdog_timeout_flag = 1'b1;  // see RL4
                            d.flags.power_down_flag       = 1'b1;  // see RL11
                            d.init.int_enable        = q.init.int_enable;
                            d.init.timer_enable      = q.init.timer_enable;
                            d.init.port_dir          = q.init.port_dir;
                            d.init.analog_input_pins = q.init.analog_input_pins;
                        end
                        default: begin
                            // power-on: cleared flags and a full reload
                            d.flags.watchdog_timeout_flag = 1'b0;  // see RL1
                            d.flags.power_down_flag       = 1'b0;  // see RL1
                            d.init.int_enable        = `RCIS_INTEN_RESET;  // see RL5
                            d.init.watchdog_clear    = 1'b1;  // see RL6
                            d.init.timer_enable      = `RCIS_TIMER_EN_RESET;  // see RL7
                            d.init.port_dir          = `RCIS_PORT_DIR_RESET;  // see RL8
                            d.init.analog_input_pins = `RCIS_ANALOG_SEL_RESET;  // see RL8
                        end
                    endcase
                    d.cause = RCIS_CAUSE_NONE;
                end else begin
                    d.count = q.count + 11'h001;
                end
            end
            default: d.state = RCIS_ST_HOLD;
        endcase
    end

    // ---------------------------------------------------------------
    // state register; power-on is the asynchronous reset
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // power-on wins over any other source: it is the async reset
            q.state                       <= RCIS_ST_HOLD;  // see RL13
            q.cause                       <= RCIS_CAUSE_NONE;
            q.por_seen                    <= 1'b1;
            q.count                       <= 11'h000;
            q.core_reset_n                <= 1'b0;  // see RL14
            q.flags.watchdog_timeout_flag <= 1'b0;  // see RL1
            q.flags.power_down_flag       <= 1'b0;  // see RL1
            q.init.pc                     <= `RCIS_PC_RESET;  // see RL9
            q.init.sp                     <= `RCIS_SP_RESET;  // see RL9
            q.init.int_enable             <= `RCIS_INTEN_RESET;  // see RL5
            q.init.watchdog_clear         <= 1'b1;  // see RL6
            q.init.timer_enable           <= `RCIS_TIMER_EN_RESET;  // see RL7
            q.init.port_dir               <= `RCIS_PORT_DIR_RESET;  // see RL8
            q.init.analog_input_pins      <= `RCIS_ANALOG_SEL_RESET;  // see RL8
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, each straight from the state register
    // ---------------------------------------------------------------
    assign core_reset_n_out = q.core_reset_n;  // see RL14
    assign flags_out        = q.flags;
    assign init_out         = q.init;
    assign por_seen_out     = q.por_seen;
endmodule : rcis_top

// ---- sim/rcis_src_model.sv ----
// reset source model: external pin, supply monitor and watchdog
`timescale 1ns/1ps
module rcis_src_model (
    // clock
    input  wire logic ref_clk_in,
    // reset sources
    output logic      pin_n_out,
    output logic      lvr_out,
    output logic      wdt_out,
    output logic      lowpwr_out
);
    initial begin
        pin_n_out = 1'h1;
        lvr_out = 1'h0;
        wdt_out = 1'h0;
        lowpwr_out = 1'h0;
    end
    // mask {watchdog, low voltage, pin}; held len cycles, changed off the falling edge
    task automatic pulse(input logic [2:0] mask, input logic lp, input int len);
        @(negedge ref_clk_in);
        lowpwr_out = lp;
        pin_n_out = ~mask[0];
        lvr_out = mask[1];
        wdt_out = mask[2];
        repeat (len) @(negedge ref_clk_in);
        pin_n_out = 1'h1;
        lvr_out = 1'h0;
        wdt_out = 1'h0;
        lowpwr_out = 1'h0;
    endtask : pulse
endmodule : rcis_src_model

// ---- sim/rcis_top_props.sv ----
// assertions for the reset cause block
`timescale 1ns/1ps
`include "rcis_defines.svh"
module rcis_top_props
    import rcis_pkg::*;
(
    input wire logic          ref_clk_in,
    input wire logic          resetn_in,
    input wire logic          external_reset_pin_n_in,
    input wire logic          low_voltage_reset_in,
    input wire logic          watchdog_timer_timeout_in,
    input wire logic          low_power_mode_in,
    input wire rcis_clk_src_t clk_src_in,
    input wire logic          core_reset_n_out,
    input wire rcis_flags_t   flags_out,
    input wire rcis_init_t    init_out,
    input wire logic          por_seen_out
);
    logic [11:0] quiet_q;
    logic [11:0] sst;
    logic        src;
    assign src = ~external_reset_pin_n_in | low_voltage_reset_in | watchdog_timer_timeout_in;
    assign sst = (clk_src_in == RCIS_CLK_XTAL) ? 12'(`RCIS_SST_XTAL_CLKS) :
                 (clk_src_in == RCIS_CLK_INTERNAL_SLOW_RC) ? 12'(`RCIS_SST_INTERNAL_SLOW_RC_CLKS) :
                 12'(`RCIS_SST_RC_CLKS);
    // cycles with every source quiet while the core is still held
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) quiet_q <= 12'h000;
        else if (core_reset_n_out | src) quiet_q <= 12'h000;
        else quiet_q <= quiet_q + 12'h001;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    por_flags_a: assert property (
        $rose(core_reset_n_out) && $past(por_seen_out) |-> flags_out == 2'h0)
        else $error("flags not clear after power-on");
    flag_hold_a: assert property (
        core_reset_n_out && $past(core_reset_n_out) |-> $stable(flags_out))
        else $error("flags moved while running");
    pd_with_to_a: assert property (
        $rose(flags_out.power_down_flag) |-> flags_out.watchdog_timeout_flag)
        else $error("power-down flag set without timeout flag");
    por_init_a: assert property (
        $rose(core_reset_n_out) && $past(por_seen_out) |-> init_out.int_enable == 8'h00
        && init_out.timer_enable == 2'h0 && init_out.port_dir == 8'hFF
        && init_out.analog_input_pins == 12'hFFF) else $error("bad post power-on state");
    wdt_pulse_a: assert property (
        init_out.watchdog_clear && core_reset_n_out |=> !init_out.watchdog_clear)
        else $error("watchdog clear longer than one cycle");
    pc_sp_zero_a: assert property (
        $rose(core_reset_n_out) |-> init_out.pc == 13'h0000 && init_out.sp == 4'h0)
        else $error("pc or sp not zero at release");
    startup_delay_a: assert property (
        $rose(core_reset_n_out) |-> quiet_q >= sst && quiet_q <= sst + 12'h008)
        else $error("start-up delay out of range");
    src_holds_a: assert property (
        src [*4] |-> !core_reset_n_out) else $error("core released with source active");
    por_once_a: assert property (
        core_reset_n_out && $past(core_reset_n_out) |-> !por_seen_out)
        else $error("power-on marker stuck");
endmodule : rcis_top_props
bind rcis_top rcis_top_props chk_u (.ref_clk_in, .resetn_in, .external_reset_pin_n_in,
    .low_voltage_reset_in, .watchdog_timer_timeout_in, .low_power_mode_in, .clk_src_in,
    .core_reset_n_out, .flags_out, .init_out, .por_seen_out);

// ---- sim/tb.sv ----
// self-checking bench for the reset cause block
`timescale 1ns/1ps
module tb
    import rcis_pkg::*;
;
    typedef struct packed {
        logic [2:0]  mask;
        logic        lp;
        rcis_flags_t flags;
    } rcis_row_t;
    logic          ref_clk_in = 1'h0;
    logic          resetn_in = 1'h0;
    logic          pin_n, low_voltage_reset, wdt, lp;
    rcis_clk_src_t clk_src_in;
    logic          core_reset_n_out;
    logic          por_seen_out;
    rcis_flags_t   flags_out;
    rcis_init_t    init_out;
    int            bad_count = 0;
    int            n_compared = 0;
    int            n;
    // pin plus watchdog first: a plain watchdog would have set the timeout flag
    rcis_row_t     rows [5] = '{'{3'h5, 1'h0, 2'h0}, '{3'h4, 1'h0, 2'h2},
                                '{3'h1, 1'h0, 2'h2}, '{3'h4, 1'h1, 2'h3}, '{3'h2, 1'h0, 2'h3}};
    rcis_clk_src_t cs_tab [3] = '{RCIS_CLK_XTAL, RCIS_CLK_INTERNAL_SLOW_RC, RCIS_CLK_RC};
    int            sst_tab [3] = '{1024, 2, 16};
    always #50 ref_clk_in = ~ref_clk_in;
    rcis_src_model src_u (.ref_clk_in(ref_clk_in), .pin_n_out(pin_n), .lvr_out(low_voltage_reset),
                          .wdt_out(wdt), .lowpwr_out(lp));
    rcis_top dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .external_reset_pin_n_in(pin_n), .low_voltage_reset_in(low_voltage_reset),
        .watchdog_timer_timeout_in(wdt), .low_power_mode_in(lp), .clk_src_in(clk_src_in),
        .core_reset_n_out(core_reset_n_out), .flags_out(flags_out), .init_out(init_out),
        .por_seen_out(por_seen_out));
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task automatic chk_flags(input string what, input rcis_flags_t exp, input rcis_flags_t got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_flags
    task automatic chk_bits(input string what, input logic [47:0] exp, input logic [47:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bits
    // bounded wait for the core to leave reset, counted in cycles
    task automatic wait_up(output int cnt);
        cnt = 0;
        while (core_reset_n_out !== 1'h1 && cnt < 3000) begin
            @(negedge ref_clk_in);
            cnt++;
        end
    endtask : wait_up
    // wd_exp: whether this release clears the watchdog for one cycle
    task automatic chk_state(input logic wd_exp);
        chk_bits("pc sp", 48'h0, 48'({init_out.pc, init_out.sp}));
        chk_bits("peripherals", 48'({8'h00, 2'h0, 8'hFF, 12'hFFF}), 48'({init_out.int_enable,
            init_out.timer_enable, init_out.port_dir, init_out.analog_input_pins}));
        chk_bits("watchdog pulse", 48'(wd_exp), 48'(init_out.watchdog_clear));
        @(negedge ref_clk_in);
        chk_bits("watchdog clear", 48'h0, 48'(init_out.watchdog_clear));
    endtask : chk_state
    initial begin
        clk_src_in = cs_tab[0];
        repeat (20) @(negedge ref_clk_in);
        // ---------------------------------------------------------------
        // power-on per clock source
        // ---------------------------------------------------------------
        for (int i = 0; i < 3; i++) begin
            clk_src_in = cs_tab[i];
            resetn_in = 1'h0;
            repeat (2) @(negedge ref_clk_in);
            chk_bits("por seen", 48'h1, 48'(por_seen_out));
            resetn_in = 1'h1;
            wait_up(n);
            chk_bits("delay ok", 48'h1, 48'(n >= sst_tab[i] && n <= sst_tab[i] + 8));
            chk_flags("por flags", 2'h0, flags_out);
            chk_state(1'h1);
        end
        // ---------------------------------------------------------------
        // resets in run and low-power mode
        // ---------------------------------------------------------------
        foreach (rows[i]) begin
            src_u.pulse(rows[i].mask, rows[i].lp, 6);
            wait_up(n);
            chk_flags("flags", rows[i].flags, flags_out);
            chk_state(!rows[i].lp);
        end
        // a source returning during start-up restarts the full delay
        src_u.pulse(3'h2, 1'h0, 6);
        repeat (8) @(negedge ref_clk_in);
        src_u.pulse(3'h2, 1'h0, 6);
        wait_up(n);
        chk_bits("restart delay", 48'h1, 48'(n >= 16 && n <= 24));
        summarize();
    end
    initial begin
        repeat (10000) @(posedge ref_clk_in);
        bad_count++;
        summarize();
    end
endmodule : tb
